/* hw/msg_resp_cfg.svh */
// constants for the bus message responder: offsets, field positions, reset values, codes
// assumes a 32-bit classic wishbone slave, word aligned registers
`ifndef MSG_RESP_CFG_SVH
`define MSG_RESP_CFG_SVH
// How it works
// - take loop address n, forward n plus one
// - clear outside error aborts measurement, clears signatures
// - clear in error state clears error only
// - listener message 0/1 disables/enables auto-addressing when listening, no auto address held
// - async enable lets device originate identify frames
// - end-or-identify ends message when listening, no attention
// - trigger when listening marks next measurement triggered
// - go-to-local when listening keeps lockout
// - identify frame gets own poll bit, passed on
// - listen/talk only when address matches own
// - local lockout disables clear/local key
// - no-operation disables asynchronous service requests
// - not-ready suspends sending until send-data
// - not-remote-enable goes local, clears lockout
// - poll enable stores value; disable when listening, unconfigure always, turn off
// - remote enable enters remote at next listen addressing
// - accessory id request returns value 81
// - serial poll or status request sends status byte
// - unlisten, untalk, interface clear drop states
// - status bits set regardless of mask
// - ignore received service request; send when enabled
// - status byte weights 1,2,4,16,32,64
// - trigger bit needs trigger status enable first

// register byte offsets
`define OFS_MSG      8'h00
`define OFS_STATUS   8'h04
`define OFS_MASK     8'h08
`define OFS_STATE    8'h0C
`define OFS_CTRL     8'h10
`define OFS_EVENT    8'h14
`define OFS_REPLY    8'h18
`define OFS_SWADDR   8'h1C
// message register: code in [4:0], argument in [12:8]
`define MSG_ARG_LSB  8
`define ADDR_W       5
// status byte bit positions
`define SB_DATA      0
`define SB_TRIG      1
`define SB_ERR       2
`define SB_LOCAL     4
`define SB_PWR       5
`define SB_SRQ       6
// ctrl register bits (write one to act)
`define CT_DATA_RDY  0
`define CT_PROBE_SW  1
`define CT_ERROR     2
`define CT_TRIG_EN   3
`define CT_ERR_CLR   4
`define CT_STAT_CLR  5
`define CT_NEED_SVC  6
// reply values
`define ACCESSORY_ID 8'h51
`define RESET_MASK   8'h00
`define WB_BAD_READ  32'h0000_0000
`endif

/* hw/msg_resp_pkg.sv */
// types shared by the bus message responder
// assumes constants from msg_resp_cfg.svh
package msg_resp_pkg;
    typedef enum logic [4:0] {
        MSG_NULL, MSG_ATN, MSG_DCL, MSG_SDC, MSG_GET, MSG_GTL, MSG_LLO, MSG_NRE,
        MSG_REN, MSG_IFC, MSG_LAD, MSG_TAD, MSG_UNL, MSG_UNT, MSG_AAD, MSG_AAU,
        MSG_DDL, MSG_EAR, MSG_EOI, MSG_IDY, MSG_NOP, MSG_NRD, MSG_SDA, MSG_PPE,
        MSG_PPD, MSG_PPU, MSG_SAI, MSG_SDI, MSG_SPE, MSG_SPD, MSG_SST, MSG_SRQ
    } msg_t;
    typedef struct packed {
        logic       fwdValid;
        logic [4:0] fwdAddr;
        logic       idyValid;
        logic       idyBit;
        logic       statusSend;
        logic       accIdSend;
        logic       devIdSend;
        logic       msgEnd;
    } link_out_t;
    typedef struct packed {
        logic abortMeas;
        logic resetGate;
        logic clearSig;
        logic trigNext;
    } meas_ctl_t;
endpackage

/* hw/bus_message_responder.sv */
// bus message responder: interface message state machine behind a wishbone slave
// assumes software writes each received message into the message register
`timescale 1ns/1ps
`include "msg_resp_cfg.svh"
module bus_message_responder
    import msg_resp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output link_out_t        linkOut,
    output meas_ctl_t        measCtl,
    output logic             srqOut,
    output logic             remoteLed,
    output logic             talkLed,
    output logic             listenLed,
    output logic             frontKeysOff,
    output logic             clearKeyOff,
    output logic             sendHold
);
    logic        access;
    logic        wrEn;
    logic        msgWr;
    msg_t        msgCode;
    logic [4:0]  msgArg;
    logic [4:0]  ownAddr;
    logic [4:0]  swAddr_r;
    logic [4:0]  autoAddr_r;
    logic        autoAddrValid_r;
    logic        autoEn_r;
    logic        listener_r;
    logic        talker_r;
    logic        remote_r;
    logic        renPend_r;
    logic        lockout_r;
    logic        asyncEn_r;
    logic        ppEn_r;
    logic [7:0]  ppCfg_r;
    logic        suspend_r;
    logic        atn_r;
    logic        errState_r;
    logic        trigEn_r;
    logic [7:0]  mask_r;
    logic        dataRdy_r;
    logic        trigOcc_r;
    logic        errOcc_r;
    logic        pwrOn_r;
    logic        probeTrig;
    logic        gateTrig;
    logic        doClear;
    logic [7:0]  statusByte;
    logic        srqFlag;
    logic [7:0]  events_r;
    logic [31:0] rdData;
    logic [31:0] ctrlW;

    assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrEn    = access & wb_we_i & wb_sel_i[0];
    assign msgWr   = wrEn & (wb_adr_i == `OFS_MSG);
    assign msgCode = msg_t'(wb_dat_i[4:0]);
    assign msgArg  = wb_dat_i[`MSG_ARG_LSB +: `ADDR_W];
    assign ctrlW   = (wrEn && wb_adr_i == `OFS_CTRL) ? wb_dat_i : 32'h0000_0000;
    assign ownAddr = (autoEn_r && autoAddrValid_r) ? autoAddr_r : swAddr_r;

    // clear from device clear or selected clear while listening
    assign doClear = msgWr && (msgCode == MSG_DCL ||
                               (msgCode == MSG_SDC && listener_r));
    assign gateTrig  = msgWr && msgCode == MSG_GET && listener_r;
    assign probeTrig = ctrlW[`CT_PROBE_SW] | gateTrig;

    // bus ack, one cycle per access
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= rdData;
        end
    end

    always_comb begin
        unique case (wb_adr_i)
            `OFS_STATUS: rdData = {24'h00_0000, statusByte};
            `OFS_MASK:   rdData = {24'h00_0000, mask_r};
            `OFS_STATE:  rdData = {16'h0000, ppCfg_r, suspend_r, asyncEn_r, ppEn_r,
                                   lockout_r, remote_r, talker_r, listener_r, autoEn_r};
            `OFS_CTRL:   rdData = {29'h0000_0000, trigEn_r, errState_r, atn_r};
            `OFS_EVENT:  rdData = {24'h00_0000, events_r};
            `OFS_REPLY:  rdData = {24'h00_0000, `ACCESSORY_ID};
            `OFS_SWADDR: rdData = {27'h000_0000, ownAddr};
            default:     rdData = `WB_BAD_READ;
        endcase
    end

    // software-set address and service mask
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            swAddr_r <= 5'h00;
            mask_r   <= `RESET_MASK;
        end else begin
            if (wrEn && wb_adr_i == `OFS_SWADDR)
                swAddr_r <= wb_dat_i[4:0];
            if (wrEn && wb_adr_i == `OFS_MASK)
                mask_r <= wb_dat_i[7:0];
        end
    end

    // auto addressing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            autoAddr_r      <= 5'h00;
            autoAddrValid_r <= 1'b0;
            autoEn_r        <= 1'b1;
        end else if (msgWr) begin
            if (msgCode == MSG_AAD) begin
                autoAddr_r      <= msgArg;
                autoAddrValid_r <= 1'b1;
            end else if (msgCode == MSG_AAU) begin
                autoAddrValid_r <= 1'b0;
            end else if (msgCode == MSG_DDL && listener_r && !autoAddrValid_r) begin
                if (msgArg == 5'h00)
                    autoEn_r <= 1'b0;
                else if (msgArg == 5'h01)
                    autoEn_r <= 1'b1;
            end
        end
    end

    // listener and talker
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            listener_r <= 1'b0;
            talker_r   <= 1'b0;
        end else if (msgWr) begin
            unique case (msgCode)
                MSG_LAD: if (msgArg == ownAddr) listener_r <= 1'b1;
                MSG_TAD: if (msgArg == ownAddr) talker_r <= 1'b1;
                MSG_UNL: listener_r <= 1'b0;
                MSG_UNT: talker_r <= 1'b0;
                MSG_IFC: begin
                    listener_r <= 1'b0;
                    talker_r   <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // remote, local and lockout
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            remote_r  <= 1'b0;
            renPend_r <= 1'b0;
            lockout_r <= 1'b0;
        end else if (msgWr) begin
            unique case (msgCode)
                MSG_REN: renPend_r <= 1'b1;
                MSG_LAD: if (renPend_r && msgArg == ownAddr) remote_r <= 1'b1;
                MSG_GTL: if (listener_r) remote_r <= 1'b0;
                MSG_LLO: lockout_r <= 1'b1;
                MSG_NRE: begin
                    remote_r  <= 1'b0;
                    renPend_r <= 1'b0;
                    lockout_r <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // async requests, parallel poll, send suspension, attention
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            asyncEn_r <= 1'b0;
            ppEn_r    <= 1'b0;
            ppCfg_r   <= 8'h00;
            suspend_r <= 1'b0;
            atn_r     <= 1'b0;
        end else if (msgWr) begin
            unique case (msgCode)
                MSG_EAR: asyncEn_r <= 1'b1;
                MSG_NOP: asyncEn_r <= 1'b0;
                MSG_PPE: begin
                    ppEn_r  <= 1'b1;
                    ppCfg_r <= {3'h0, msgArg};
                end
                MSG_PPD: if (listener_r) ppEn_r <= 1'b0;
                MSG_PPU: ppEn_r <= 1'b0;
                MSG_NRD: suspend_r <= 1'b1;
                MSG_SDA: suspend_r <= 1'b0;
                MSG_ATN: atn_r <= wb_dat_i[`MSG_ARG_LSB];
                default: ;
            endcase
        end
    end

    // error state and trigger-bit enable
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            errState_r <= 1'b0;
            trigEn_r   <= 1'b0;
        end else begin
            if (ctrlW[`CT_ERROR])
                errState_r <= 1'b1;
            else if ((doClear && errState_r) || ctrlW[`CT_ERR_CLR])
                errState_r <= 1'b0;
            if (ctrlW[`CT_TRIG_EN])
                trigEn_r <= 1'b1;
        end
    end

    // status condition bits, set wins over clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dataRdy_r <= 1'b0;
            trigOcc_r <= 1'b0;
            errOcc_r  <= 1'b0;
            pwrOn_r   <= 1'b1;
        end else begin
            if (ctrlW[`CT_DATA_RDY])
                dataRdy_r <= 1'b1;
            else if (ctrlW[`CT_STAT_CLR])
                dataRdy_r <= 1'b0;
            if (probeTrig && trigEn_r)
                trigOcc_r <= 1'b1;
            else if (ctrlW[`CT_STAT_CLR])
                trigOcc_r <= 1'b0;
            if (ctrlW[`CT_ERROR])
                errOcc_r <= 1'b1;
            else if (ctrlW[`CT_STAT_CLR])
                errOcc_r <= 1'b0;
            if (ctrlW[`CT_STAT_CLR])
                pwrOn_r <= 1'b0;
        end
    end

    // status byte layout and service request
    always_comb begin
        statusByte              = 8'h00;
        statusByte[`SB_DATA]    = dataRdy_r;
        statusByte[`SB_TRIG]    = trigOcc_r;
        statusByte[`SB_ERR]     = errOcc_r;
        statusByte[`SB_LOCAL]   = ~remote_r;
        statusByte[`SB_PWR]     = pwrOn_r;
        srqFlag                 = |(statusByte & mask_r);
        statusByte[`SB_SRQ]     = srqFlag;
    end

    // message events seen by software
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            events_r <= 8'h00;
        else if (msgWr)
            events_r <= {3'h0, msgCode};
    end

    // registered outputs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            linkOut      <= '0;
            measCtl      <= '0;
            srqOut       <= 1'b0;
            remoteLed    <= 1'b0;
            talkLed      <= 1'b0;
            listenLed    <= 1'b0;
            frontKeysOff <= 1'b0;
            clearKeyOff  <= 1'b0;
            sendHold     <= 1'b0;
        end else begin
            linkOut.fwdValid   <= msgWr && msgCode == MSG_AAD;
            linkOut.fwdAddr    <= msgArg + 5'h01;
            linkOut.idyValid   <= (msgWr && msgCode == MSG_IDY) ||
                                  (asyncEn_r && ctrlW[`CT_NEED_SVC]);
            linkOut.idyBit     <= ppEn_r & srqFlag;
            linkOut.statusSend <= msgWr && (msgCode == MSG_SPE ||
                                            msgCode == MSG_SST);
            linkOut.accIdSend  <= msgWr && msgCode == MSG_SAI;
            linkOut.devIdSend  <= msgWr && msgCode == MSG_SDI;
            linkOut.msgEnd     <= msgWr && msgCode == MSG_EOI &&
                                  !atn_r && listener_r;
            measCtl.abortMeas  <= doClear && !errState_r;
            measCtl.resetGate  <= doClear && !errState_r;
            measCtl.clearSig   <= doClear && !errState_r;
            measCtl.trigNext   <= probeTrig;
            srqOut             <= srqFlag;
            remoteLed          <= remote_r;
            talkLed            <= talker_r;
            listenLed          <= listener_r;
            frontKeysOff       <= remote_r;
            clearKeyOff        <= lockout_r;
            sendHold           <= suspend_r;
        end
    end
endmodule

/* dv/msg_resp_sva.sv */
// port assertions for the bus message responder
// assumes binding onto the responder top, single clock domain
`timescale 1ns/1ps
`include "msg_resp_cfg.svh"
module msg_resp_sva
    import msg_resp_pkg::*;
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire link_out_t   linkOut,
    input wire meas_ctl_t   measCtl,
    input wire logic        srqOut,
    input wire logic        remoteLed,
    input wire logic        talkLed,
    input wire logic        listenLed,
    input wire logic        frontKeysOff,
    input wire logic        clearKeyOff,
    input wire logic        sendHold
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic msgWr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_MSG;
    wire msg_t code = msg_t'(wb_dat_i[4:0]);
    wire logic anyPulse = |{measCtl, linkOut.fwdValid, linkOut.idyValid, linkOut.statusSend,
        linkOut.accIdSend, linkOut.devIdSend, linkOut.msgEnd};
    property p_ackNext; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ackNext: assert property (p_ackNext) else $error("ack not one cycle after request");
    property p_pulseAck; anyPulse |-> wb_ack_o && $past(wb_we_i); endproperty
    a_pulseAck: assert property (p_pulseAck) else $error("pulse without write ack");
    property p_fwd;
        msgWr && code == MSG_AAD |=> linkOut.fwdValid && linkOut.fwdAddr == $past(wb_dat_i[12:8]) + 5'h01;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded address wrong");
    property p_clr; measCtl.abortMeas |-> measCtl.resetGate && measCtl.clearSig; endproperty
    a_clr: assert property (p_clr) else $error("clear pulses split");
    property p_acc; msgWr && code == MSG_SAI |=> linkOut.accIdSend; endproperty
    a_acc: assert property (p_acc) else $error("accessory reply missing");
    property p_sts; msgWr && (code == MSG_SST || code == MSG_SPE) |=> linkOut.statusSend; endproperty
    a_sts: assert property (p_sts) else $error("status send missing");
    property p_srqIgn; msgWr && code == MSG_SRQ |=> !anyPulse; endproperty
    a_srqIgn: assert property (p_srqIgn) else $error("service request not ignored");
    property p_nre; msgWr && code == MSG_NRE |=> ##1 !remoteLed && !clearKeyOff; endproperty
    a_nre: assert property (p_nre) else $error("local or lockout wrong");
    property p_ifc; msgWr && code == MSG_IFC |=> ##1 (!talkLed && !listenLed) [*2]; endproperty
    a_ifc: assert property (p_ifc) else $error("addressing kept");
    property p_hold; $rose(sendHold) |-> $past(msgWr, 2) && $past(code, 2) == MSG_NRD; endproperty
    a_hold: assert property (p_hold) else $error("hold without request");
    property p_keys; frontKeysOff == remoteLed; endproperty
    a_keys: assert property (p_keys) else $error("keys differ from remote");
    c_fwd: cover property (msgWr && code == MSG_AAD);
    c_idy: cover property (linkOut.idyValid && linkOut.idyBit);
    c_srq: cover property ($rose(srqOut));
endmodule

/* dv/loop_ctrl_model.sv */
// far side controller: classic wishbone single cycles
// assumes the bench calls xfer just after a rising edge
`timescale 1ns/1ps
module loop_ctrl_model (
    input  wire logic        mclk,
    input  wire logic        ackIn,
    output logic      [7:0]  adr,
    output logic      [31:0] dat,
    output logic      [3:0]  sel,
    output logic             we,
    output logic             cyc,
    output logic             stb
);
    initial begin
        {adr, dat, sel, we, cyc, stb} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        // ack is looked at on rising edges only
        do begin
            @(posedge mclk);
            n++;
        end while (ackIn !== 1'b1 && n < 50);
        // released address and data lines invert so stale values are never trusted; we and sel hold
        cyc <= 1'b0;
        stb <= 1'b0;
        adr <= ~a;
        dat <= ~d;
        @(posedge mclk);
    endtask
endmodule

/* dv/bus_message_responder_tb_top.sv */
// self-checking bench for the bus message responder
// assumes the controller model and the port checker beside it
`timescale 1ns/1ps
`include "msg_resp_cfg.svh"
module bus_message_responder_tb_top import msg_resp_pkg::*;;
    typedef struct packed {logic isRd; logic [31:0] exp; logic [31:0] msk;} note_t;
    logic mclk, nrst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, srqOut, remoteLed, talkLed;
    logic listenLed, frontKeysOff, clearKeyOff, sendHold;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i;
    link_out_t linkOut, lo;
    meas_ctl_t measCtl;
    note_t notes[$], nt;
    int numErrors, checked, i;
    logic [4:0] sw, n;
    logic [7:0] rm;
    msg_t cds[7] = '{MSG_SST, MSG_SPE, MSG_SAI, MSG_SDI, MSG_SPD, MSG_SRQ, MSG_NULL};
    logic [15:0] pvs[7] = '{16'h0080, 16'h0080, 16'h0040, 16'h0020, 16'h0, 16'h0, 16'h0};
    bus_message_responder dut_u(.mclk(mclk), .nrst(nrst), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .linkOut(linkOut),
        .measCtl(measCtl), .srqOut(srqOut), .remoteLed(remoteLed), .talkLed(talkLed),
        .listenLed(listenLed), .frontKeysOff(frontKeysOff), .clearKeyOff(clearKeyOff),
        .sendHold(sendHold));
    loop_ctrl_model ctl_u(.mclk(mclk), .ackIn(wb_ack_o), .adr(wb_adr_i), .dat(wb_dat_i),
        .sel(wb_sel_i), .we(wb_we_i), .cyc(wb_cyc_i), .stb(wb_stb_i));
    task automatic report(input string nm, input logic [31:0] e, input logic [31:0] s);
        numErrors++;
        $display("mismatch %s expected %h seen %h", nm, e, s);
    endtask
    task automatic chkRd(input logic [31:0] e, input logic [31:0] s, input logic [31:0] m);
        checked++;
        if ((s & m) !== (e & m)) report("readData", e & m, s & m);
    endtask
    task automatic chkPulse(input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) report("pulses", {16'h0, e}, {16'h0, s});
    endtask
    task automatic lvl(input string nm, input logic e, ref logic s);
        @(negedge mclk);
        checked++;
        if (s !== e) report(nm, {31'h0, e}, {31'h0, s});
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [15:0] p);
        notes.push_back('{1'b0, {16'h0, p}, 32'hFFFF});
        ctl_u.xfer(1'b1, a, d);
    endtask
    task automatic msg(input msg_t c, input logic [4:0] g, input logic [15:0] p);
        wr(`OFS_MSG, {19'h0, g, 3'h0, c}, p);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{1'b1, e, m});
        ctl_u.xfer(1'b0, a, 32'h0);
    endtask
    task automatic test_done;
        numErrors += notes.size();
        if (numErrors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(negedge mclk) begin
        if (wb_ack_o === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            lo = linkOut;
            if (!lo.fwdValid) lo.fwdAddr = 5'h00;
            if (!lo.idyValid) lo.idyBit = 1'b0;
            if (nt.isRd) chkRd(nt.exp, wb_dat_o, nt.msk);
            else chkPulse(nt.exp[15:0], {lo, measCtl});
        end
    end
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        numErrors++;
        test_done();
    end
    initial begin
        nrst = 1'b0;
        numErrors = 0;
        checked = 0;
        rm = $urandom(32'hAD3E8B8D);
        rm = 8'($urandom());
        sw = 5'($urandom_range(30, 0));
        n = 5'($urandom());
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(`OFS_STATUS, 32'h30, 32'hFF);
        rd(`OFS_REPLY, 32'h51, 32'hFF);
        rd(8'h20, 32'h0, 32'hFFFF_FFFF);
        wr(`OFS_MASK, {24'h0, rm}, 16'h0);
        rd(`OFS_MASK, {24'h0, rm}, 32'hFF);
        wr(`OFS_MASK, 32'h0, 16'h0);
        wr(`OFS_SWADDR, {27'h0, sw}, 16'h0);
        msg(MSG_ATN, 5'h0, 16'h0);
        msg(MSG_GET, 5'h0, 16'h0);
        msg(MSG_LAD, sw ^ 5'h01, 16'h0);
        rd(`OFS_STATE, 32'h0, 32'h2);
        msg(MSG_REN, 5'h0, 16'h0);
        msg(MSG_LAD, sw, 16'h0);
        rd(`OFS_STATE, 32'hA, 32'hA);
        msg(MSG_GET, 5'h0, 16'h0001);
        msg(MSG_SDC, 5'h0, 16'h000E);
        wr(`OFS_CTRL, 32'h4, 16'h0);
        msg(MSG_DCL, 5'h0, 16'h0);
        rd(`OFS_CTRL, 32'h0, 32'h2);
        msg(MSG_DCL, 5'h0, 16'h000E);
        msg(MSG_EOI, 5'h0, 16'h0010);
        msg(MSG_ATN, 5'h1, 16'h0);
        msg(MSG_EOI, 5'h0, 16'h0);
        msg(MSG_ATN, 5'h0, 16'h0);
        for (i = 0; i < 7; i++) msg(cds[i], 5'h0, pvs[i]);
        wr(`OFS_CTRL, 32'h20, 16'h0);
        wr(`OFS_CTRL, 32'h3, 16'h0001);
        rd(`OFS_STATUS, 32'h01, 32'h43);
        wr(`OFS_MASK, 32'h2, 16'h0);
        wr(`OFS_CTRL, 32'h8, 16'h0);
        wr(`OFS_CTRL, 32'h2, 16'h0001);
        rd(`OFS_STATUS, 32'h43, 32'h47);
        lvl("srqOut", 1'b1, srqOut);
        msg(MSG_PPE, 5'h1, 16'h0);
        msg(MSG_IDY, 5'h0, 16'h0300);
        wr(`OFS_CTRL, 32'h40, 16'h0);
        msg(MSG_EAR, 5'h0, 16'h0);
        wr(`OFS_CTRL, 32'h40, 16'h0300);
        msg(MSG_NOP, 5'h0, 16'h0);
        wr(`OFS_CTRL, 32'h40, 16'h0);
        msg(MSG_LLO, 5'h0, 16'h0);
        lvl("clearKeyOff", 1'b1, clearKeyOff);
        msg(MSG_GTL, 5'h0, 16'h0);
        rd(`OFS_STATE, 32'h10, 32'h18);
        msg(MSG_NRE, 5'h0, 16'h0);
        rd(`OFS_STATE, 32'h0, 32'h18);
        msg(MSG_NRD, 5'h0, 16'h0);
        lvl("sendHold", 1'b1, sendHold);
        msg(MSG_SDA, 5'h0, 16'h0);
        lvl("sendHold", 1'b0, sendHold);
        msg(MSG_UNL, 5'h0, 16'h0);
        rd(`OFS_STATE, 32'h0, 32'h2);
        msg(MSG_TAD, sw, 16'h0);
        msg(MSG_LAD, sw, 16'h0);
        rd(`OFS_STATE, 32'h6, 32'h6);
        msg(MSG_IFC, 5'h0, 16'h0);
        rd(`OFS_STATE, 32'h0, 32'h6);
        msg(MSG_PPD, 5'h0, 16'h0);
        rd(`OFS_STATE, 32'h20, 32'h20);
        msg(MSG_PPU, 5'h0, 16'h0);
        rd(`OFS_STATE, 32'h0, 32'h20);
        msg(MSG_AAD, n, {1'b1, n + 5'h01, 10'h0});
        msg(MSG_LAD, n, 16'h0);
        msg(MSG_DDL, 5'h0, 16'h0);
        rd(`OFS_STATE, 32'h3, 32'h3);
        msg(MSG_AAU, 5'h0, 16'h0);
        msg(MSG_LAD, sw, 16'h0);
        msg(MSG_DDL, 5'h0, 16'h0);
        rd(`OFS_STATE, 32'h2, 32'h3);
        msg(MSG_DDL, 5'h1, 16'h0);
        rd(`OFS_STATE, 32'h3, 32'h3);
        test_done();
    end
endmodule
bind bus_message_responder msg_resp_sva chk_u(.mclk(mclk), .nrst(nrst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .linkOut(linkOut),
    .measCtl(measCtl), .srqOut(srqOut), .remoteLed(remoteLed), .talkLed(talkLed),
    .listenLed(listenLed), .frontKeysOff(frontKeysOff), .clearKeyOff(clearKeyOff),
    .sendHold(sendHold));
